// file: rtl/squib_regs_defines.svh
// Register addresses, field positions, reset values and timing counts of the register bank
`ifndef SQUIB_REGS_DEFINES_SVH
`define SQUIB_REGS_DEFINES_SVH

// Register-mode message layout
`define MSG_MODE_HI        15
`define MSG_MODE_LO        14
`define MSG_WRITE_BIT      13
`define MSG_ADDR_HI        12
`define MSG_ADDR_LO        8
`define MSG_MODE_REGISTER  2'h0

// Register addresses
`define ADDR_FAULT_MASK    5'h00
`define ADDR_CONFIG1       5'h01
`define ADDR_CONFIG2       5'h02
`define ADDR_SOFT_RESET    5'h03
`define ADDR_FAULT_BASE    5'h04

// Soft-reset key words
`define SOFT_RESET_KEY1    8'haa
`define SOFT_RESET_KEY2    8'h55

// Reset values
`define FAULT_MASK_RESET   8'h00
`define CONFIG1_RESET      8'h00
`define CONFIG2_RESET      8'h00

// Configuration 1 fields
`define CFG1_STRETCH_HI    7
`define CFG1_STRETCH_LO    6
`define CFG1_SERIAL_ARM    5

// Fault register fields
`define FLT_ODD_FLAG       7
`define FLT_EVEN_FLAG      3

// Pulse-stretch periods in microseconds and cycles at the clock rate
`define CLK_FREQ_HZ        10000000
`define STRETCH_0_US       7500
`define STRETCH_1_US       15000
`define STRETCH_2_US       30000
`define STRETCH_3_US       60000
`define US_TO_CYCLES(us)   ((us) * (`CLK_FREQ_HZ / 1000000))

`endif

// file: rtl/squib_regs_pkg.sv
// Types shared by the squib driver register bank
package squib_regs_pkg;

  // Fault codes for one channel
  typedef enum logic [2:0] {
    FLT_NONE       = 3'h0,
    FLT_LOOP_SHORT = 3'h1,
    FLT_BATT_SHORT = 3'h2,
    FLT_OPEN       = 3'h3,
    FLT_GND_SHORT  = 3'h4,
    FLT_LOW_SIDE   = 3'h5,
    FLT_HIGH_SIDE  = 3'h6,
    FLT_GND_LOSS   = 3'h7
  } fault_code_type;

  // Soft-reset sequence progress
  typedef enum logic {
    SR_IDLE,
    SR_GOT_KEY1
  } soft_reset_state_type;

endpackage : squib_regs_pkg

// file: rtl/squib_driver_config_fault_regs.sv
// Configuration, fault and soft-reset register bank of the eight-channel squib driver
`timescale 1ns/1ps
`default_nettype none
`include "squib_regs_defines.svh"

module squib_driver_config_fault_regs
  import squib_regs_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int STRETCH0_CYCLES = `US_TO_CYCLES(`STRETCH_0_US),
  parameter int STRETCH1_CYCLES = `US_TO_CYCLES(`STRETCH_1_US),
  parameter int STRETCH2_CYCLES = `US_TO_CYCLES(`STRETCH_2_US),
  parameter int STRETCH3_CYCLES = `US_TO_CYCLES(`STRETCH_3_US)
) (
  input  wire logic        clk_in,              // Logic clock, 10 MHz
  input  wire logic        resetn_in,           // Synchronous reset, active low
  input  wire logic        frame_valid_in,      // One-cycle pulse: valid 16-bit frame received
  input  wire logic [15:0] frame_data_in,       // Received 16-bit frame
  input  wire logic        deploy_active_in,    // A deployment is in progress
  input  wire logic [7:0]  deploy_cmd_in,       // One-cycle pulse per channel: command deploy
  input  wire logic [7:0]  idle_cmd_in,         // One-cycle pulse per channel: command idle
  input  wire logic [3:0]  arming_input_in,     // Discrete arming inputs, pair 6/7 at bit 3
  input  wire logic [7:0]  fault_valid_in,      // Per-channel diagnostic result strobe
  input  wire logic [7:0]  fault_cond_in [0:7], // Per-channel raw condition bits, index = code
  output logic [7:0]       reg_resp_out,        // Register-mode answer for the next frame
  output logic             diag_fault_flag_out, // Summary flag for the status response
  output logic             serial_arm_mode_out, // Serial arming interface selected
  output logic [3:0]       deploy_period_4ms_out, // Per pair: 4 ms deployment period
  output logic [3:0]       deploy_current_hi_out, // Per pair: 1.75 A deployment current
  output logic [7:0]       stretch_active_out,  // Per channel pulse-stretch timer running
  output logic             soft_reset_out       // One-cycle pulse: soft reset completed
);

  // Counter wide enough for the longest stretch period
  localparam int CNT_W = $clog2(STRETCH3_CYCLES + 1);

  // Parameters the logic cannot serve: the register layout is fixed at four
  // channel pairs, and a zero-length stretch would make a started timer vanish
  if (CHANNELS != 8) begin : g_bad_channels
    $error("Register layout serves exactly eight channels");
  end
  if (STRETCH0_CYCLES < 1) begin : g_bad_stretch_min
    $error("Shortest stretch count must be at least one cycle");
  end
  if (STRETCH1_CYCLES < STRETCH0_CYCLES || STRETCH2_CYCLES < STRETCH1_CYCLES ||
      STRETCH3_CYCLES < STRETCH2_CYCLES) begin : g_bad_stretch_order
    $error("Stretch counts must rise with the period code");
  end

  // Storage: every register of the bank is a flip-flop with a synchronous reset.
  // The configuration registers also reload on a completed soft reset, while the
  // fault registers keep their content so no logged fault is lost by it.
  // Timer state sits beside the registers because arming reads the config bits
  logic [7:0]           fault_mask_r;        // Per-channel fault report mask
  logic [7:0]           config1_r;           // Arming and stretch config
  logic [7:0]           config2_r;           // Period and current config
  logic [7:0]           fault_reg_r [0:3];   // Per-pair fault registers
  soft_reset_state_type sr_state_r;          // Soft-reset sequence state
  logic                 soft_reset_r;        // Soft-reset pulse
  logic [7:0]           resp_r;              // Answer held for next frame
  logic [2:0]           arm_sync1_r [0:3];   // Arming input synchronisers (three stages)
  logic [3:0]           arm_level_r;         // Filtered arming levels
  logic [7:0]           by_cmd_r;            // Timer started by command
  logic [CNT_W-1:0]     stretch_cnt_r [0:7]; // Stretch down counters

  // Frame decode: only register-mode frames reach the registers.
  // The other modes are served elsewhere in the device; they matter here only
  // because a frame of another mode also breaks a half-finished soft-reset sequence.
  // A frame is present for exactly one cycle, marked by frame_valid_in
  logic       is_reg_msg;  // Register-mode frame
  logic       is_write;    // Write request
  logic [4:0] addr;        // Register address
  logic [7:0] wdata;       // Write data
  logic       cfg_wr_ok;   // Config writes permitted

  // Field extraction is purely combinational; every user also checks is_reg_msg,
  // so the raw frame bits may hold anything between frames
  assign is_reg_msg = frame_valid_in &&
                      (frame_data_in[`MSG_MODE_HI:`MSG_MODE_LO] == `MSG_MODE_REGISTER);
  assign is_write   = frame_data_in[`MSG_WRITE_BIT];
  assign addr       = frame_data_in[`MSG_ADDR_HI:`MSG_ADDR_LO];
  assign wdata      = frame_data_in[7:0];
  assign cfg_wr_ok  = !deploy_active_in;

  // Fault mask register. A write is never refused: the mask only shapes the
  // summary flag and cannot disturb a deployment in progress.
  // Bit n belongs to channel n; zero keeps that channel's reporting on.
  // The fault registers below never look at it
  always_ff @(posedge clk_in) begin
    if (!resetn_in || soft_reset_r) begin
      fault_mask_r <= `FAULT_MASK_RESET;
    end else if (is_reg_msg && is_write && addr == `ADDR_FAULT_MASK) begin
      fault_mask_r <= wdata;
    end
  end

  // Deployment configuration registers, refused during deployment so that the
  // period, current and stretch settings of a running deployment cannot shift.
  // A refused write leaves the old content in place and in the answer.
  // The soft-reset reload wins over a write in the same cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in || soft_reset_r) begin
      config1_r <= `CONFIG1_RESET;
      config2_r <= `CONFIG2_RESET;
    end else if (is_reg_msg && is_write && cfg_wr_ok) begin
      if (addr == `ADDR_CONFIG1) begin
        config1_r <= wdata;
      end
      if (addr == `ADDR_CONFIG2) begin
        config2_r <= wdata;
      end
    end
  end

  // Soft-reset sequence detector: the second key must come in the very next
  // frame, so any other frame in between, of any mode, drops back to idle, except a repeated first key, which keeps waiting
  logic key1_frame; // Frame writes the first key to the soft-reset address
  logic key2_frame; // Frame writes the second key to the soft-reset address

  assign key1_frame = is_reg_msg && is_write && addr == `ADDR_SOFT_RESET &&
                      wdata == `SOFT_RESET_KEY1;
  assign key2_frame = is_reg_msg && is_write && addr == `ADDR_SOFT_RESET &&
                      wdata == `SOFT_RESET_KEY2;

  // One state step per received frame; frames are the only events that count
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sr_state_r   <= SR_IDLE;
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= 1'b0;                                       // One-cycle pulse
      if (frame_valid_in) begin
        case (sr_state_r)
          SR_IDLE: begin
            if (key1_frame) begin
              sr_state_r <= SR_GOT_KEY1;
            end
          end
          SR_GOT_KEY1: begin
            if (key2_frame) begin
              soft_reset_r <= 1'b1;
              sr_state_r   <= SR_IDLE;
            end else if (key1_frame) begin
              sr_state_r <= SR_GOT_KEY1;                          // First key again
            end else begin
              sr_state_r <= SR_IDLE;
            end
          end
          default: begin
            sr_state_r <= SR_IDLE;                                // Recover
          end
        endcase
      end
    end
  end

  // Highest-priority fault code of a channel's raw conditions: the scan lets a
  // higher code overwrite a lower one, and loss of ground is forced last so it
  // wins however the other codes are ranked; bit 0 stands for no fault
  function automatic fault_code_type pick_code(input logic [7:0] cond);
    fault_code_type code;
    code = FLT_NONE;
    for (int c = 1; c < 8; c++) begin
      if (cond[c]) begin
        code = fault_code_type'(c[2:0]);
      end
    end
    if (cond[7]) begin
      code = FLT_GND_LOSS;
    end
    return code;
  endfunction : pick_code

  // Fault registers: capture sets, read clears only the addressed one.
  // The read answer takes the old content at the same edge, so a fault caught
  // in the clearing cycle is kept for the next read instead of being lost.
  // The mask is not consulted here: masked channels still log their faults.
  // A newer result with a fault on a channel replaces its older code; a result with no fault leaves it
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int p = 0; p < 4; p++) begin
        fault_reg_r[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (is_reg_msg && !is_write && addr == (`ADDR_FAULT_BASE + 5'(p))) begin
          fault_reg_r[p] <= 8'h00;
        end
        // A new capture in the clearing cycle wins over the clear
        if (fault_valid_in[2*p+1] && pick_code(fault_cond_in[2*p+1]) != FLT_NONE) begin
          fault_reg_r[p][`FLT_ODD_FLAG]  <= 1'b1;
          fault_reg_r[p][6:4]            <= pick_code(fault_cond_in[2*p+1]);
        end
        if (fault_valid_in[2*p] && pick_code(fault_cond_in[2*p]) != FLT_NONE) begin
          fault_reg_r[p][`FLT_EVEN_FLAG] <= 1'b1;
          fault_reg_r[p][2:0]            <= pick_code(fault_cond_in[2*p]);
        end
      end
    end
  end

  // Answer for the next frame, selected by the address field.
  // A write answers with what the register holds after it, a refused write
  // with the old content; soft-reset and unmapped addresses answer zero.
  // Non-register frames leave the answer untouched
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      resp_r <= 8'h00;
    end else if (is_reg_msg) begin
      case (addr)
        `ADDR_FAULT_MASK: resp_r <= is_write ? wdata : fault_mask_r;
        `ADDR_CONFIG1:    resp_r <= (is_write && cfg_wr_ok) ? wdata : config1_r;
        `ADDR_CONFIG2:    resp_r <= (is_write && cfg_wr_ok) ? wdata : config2_r;
        `ADDR_FAULT_BASE:        resp_r <= fault_reg_r[0];
        `ADDR_FAULT_BASE + 5'h1: resp_r <= fault_reg_r[1];
        `ADDR_FAULT_BASE + 5'h2: resp_r <= fault_reg_r[2];
        `ADDR_FAULT_BASE + 5'h3: resp_r <= fault_reg_r[3];
        default:          resp_r <= 8'h00;
      endcase
    end
  end

  // Summary flag sees only unmasked channels.
  // It follows the fault registers, so reading a register also clears its
  // share of the flag; unmasking a channel with a logged fault raises it at once.
  // Combinational from flip-flops, so it settles within the cycle
  always_comb begin
    diag_fault_flag_out = 1'b0;
    for (int ch = 0; ch < 8; ch++) begin
      if (!fault_mask_r[ch] &&
          fault_reg_r[ch/2][(ch % 2 == 1) ? `FLT_ODD_FLAG : `FLT_EVEN_FLAG]) begin
        diag_fault_flag_out = 1'b1;
      end
    end
  end

  // Arming input synchronisers: change counts once stages two and three agree.
  // The pins are asynchronous; the first stage may go metastable and feeds
  // nothing but the second stage. The agreement test also drops one-cycle
  // glitches at the cost of one cycle of delay after stage three
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int a = 0; a < 4; a++) begin
        arm_sync1_r[a] <= 3'h0;
      end
      arm_level_r <= 4'h0;
    end else begin
      for (int a = 0; a < 4; a++) begin
        arm_sync1_r[a] <= {arm_sync1_r[a][1:0], arming_input_in[a]};
        if (arm_sync1_r[a][1] == arm_sync1_r[a][2]) begin
          arm_level_r[a] <= arm_sync1_r[a][2];
        end
      end
    end
  end

  // Selected stretch period in cycles.
  // A new period applies to the next start only; a timer already running keeps
  // counting down from the value it was loaded with.
  // The counts are parameters so a short run can use small values
  logic [CNT_W-1:0] stretch_load;
  always_comb begin
    case (config1_r[`CFG1_STRETCH_HI:`CFG1_STRETCH_LO])
      2'h0:    stretch_load = CNT_W'(STRETCH0_CYCLES);
      2'h1:    stretch_load = CNT_W'(STRETCH1_CYCLES);
      2'h2:    stretch_load = CNT_W'(STRETCH2_CYCLES);
      default: stretch_load = CNT_W'(STRETCH3_CYCLES);
    endcase
  end

  // Eight independent pulse-stretch timers. Branch order sets the priority:
  // a command start always reloads, an idle command stops only a timer that a
  // command started, a command-started timer runs out untouched by arming, and
  // an enabled, held arming input keeps reloading its pair's two timers.
  // A command-started timer that has run out may be restarted by arming
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int ch = 0; ch < 8; ch++) begin
        stretch_cnt_r[ch] <= '0;
      end
      by_cmd_r <= 8'h00;
    end else begin
      for (int ch = 0; ch < 8; ch++) begin
        if (deploy_cmd_in[ch]) begin
          stretch_cnt_r[ch] <= stretch_load;
          by_cmd_r[ch]      <= 1'b1;
        end else if (idle_cmd_in[ch] && by_cmd_r[ch]) begin
          stretch_cnt_r[ch] <= '0;
          by_cmd_r[ch]      <= 1'b0;
        end else if (by_cmd_r[ch] && stretch_cnt_r[ch] != '0) begin
          stretch_cnt_r[ch] <= stretch_cnt_r[ch] - 1'b1;
        end else if (config1_r[ch/2] && arm_level_r[ch/2]) begin
          stretch_cnt_r[ch] <= stretch_load;
          by_cmd_r[ch]      <= 1'b0;
        end else if (stretch_cnt_r[ch] != '0) begin
          stretch_cnt_r[ch] <= stretch_cnt_r[ch] - 1'b1;
        end else begin
          by_cmd_r[ch] <= 1'b0;
        end
      end
    end
  end

  // Outputs: a timer counts as active for as long as its counter is not zero.
  // This is the only combinational output apart from the summary flag;
  // both read flip-flops only, so neither can glitch on a frame.
  // Eight copies of one compare, one per channel
  always_comb begin
    for (int ch = 0; ch < 8; ch++) begin
      stretch_active_out[ch] = (stretch_cnt_r[ch] != '0);
    end
  end

  // Answer and configuration fields go straight out of their flip-flops;
  // the pair with channels 6/7 sits at the top bit of each 4-bit field
  assign reg_resp_out          = resp_r;
  assign serial_arm_mode_out   = config1_r[`CFG1_SERIAL_ARM];
  assign deploy_period_4ms_out = {config2_r[7], config2_r[5], config2_r[3], config2_r[1]};
  assign deploy_current_hi_out = {config2_r[6], config2_r[4], config2_r[2], config2_r[0]};
  assign soft_reset_out        = soft_reset_r;

endmodule : squib_driver_config_fault_regs
`default_nettype wire

// file: bench/spi_master_model.sv
// Register-mode frame source standing in for the SPI master
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic        clk_in,          // Logic clock
  output logic             frame_valid_out, // One-cycle frame strobe
  output logic [15:0]      frame_data_out   // Received frame word
);
  // Idle until the first frame
  initial begin
    frame_valid_out = 1'b0;
    frame_data_out  = 16'h0000;
  end

  // One whole 16-bit register frame, then the word is scrambled so no stale value lingers
  task automatic send(input logic wr, input logic [4:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    frame_valid_out = 1'b1;
    frame_data_out  = {2'h0, wr, addr, data};
    @(negedge clk_in);
    frame_valid_out = 1'b0;
    frame_data_out  = ~frame_data_out;
  endtask : send
endmodule : spi_master_model
`default_nettype wire

// file: bench/squib_regs_properties.sv
// Port-level assertions for the squib driver register bank
`timescale 1ns/1ps
`default_nettype none
module squib_regs_properties (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        frame_valid_in,
  input wire logic [15:0] frame_data_in,
  input wire logic        deploy_active_in,
  input wire logic [7:0]  deploy_cmd_in,
  input wire logic [7:0]  idle_cmd_in,
  input wire logic [7:0]  fault_valid_in,
  input wire logic [7:0]  reg_resp_out,
  input wire logic        serial_arm_mode_out,
  input wire logic [3:0]  deploy_period_4ms_out,
  input wire logic [3:0]  deploy_current_hi_out,
  input wire logic [7:0]  stretch_active_out,
  input wire logic        soft_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic       reg_frame; // Register-mode frame taken
  logic       cfg_wr;    // Register write outside a soft reload
  logic       flt_rd;    // Read of a fault register
  logic [1:0] flt_sel;   // Fault register pair selector
  logic [3:0] per_bits;  // Period bits of a config2 word
  logic [3:0] cur_bits;  // Current bits of a config2 word
  assign reg_frame = frame_valid_in && frame_data_in[15:14] == 2'h0;
  assign cfg_wr    = reg_frame && frame_data_in[13] && !soft_reset_out;
  assign flt_rd    = reg_frame && frame_data_in[13:10] == 4'h1;
  assign flt_sel   = frame_data_in[9:8];
  assign per_bits  = {frame_data_in[7], frame_data_in[5], frame_data_in[3], frame_data_in[1]};
  assign cur_bits  = {frame_data_in[6], frame_data_in[4], frame_data_in[2], frame_data_in[0]};

  resp_holds_a: assert property (!frame_valid_in |=> $stable(reg_resp_out))
    else $error("answer changed without a frame");
  unmapped_zero_a: assert property (reg_frame && frame_data_in[12:11] != 2'h0
    |=> reg_resp_out == 8'h00) else $error("unmapped address answered nonzero");
  cfg_refused_a: assert property (cfg_wr && deploy_active_in
    && frame_data_in[12:8] inside {5'h01, 5'h02} |=> $stable(serial_arm_mode_out)
    && $stable(deploy_period_4ms_out) && $stable(deploy_current_hi_out))
    else $error("config changed during deployment");
  arm_mode_wr_a: assert property (cfg_wr && !deploy_active_in && frame_data_in[12:8] == 5'h01
    |=> serial_arm_mode_out == $past(frame_data_in[5])) else $error("arming mode not stored");
  deploy_cfg_wr_a: assert property (cfg_wr && !deploy_active_in
    && frame_data_in[12:8] == 5'h02 |=> deploy_period_4ms_out == $past(per_bits)
    && deploy_current_hi_out == $past(cur_bits)) else $error("config2 outputs wrong");
  soft_defaults_a: assert property (soft_reset_out |=> !serial_arm_mode_out
    && deploy_period_4ms_out == 4'h0 && deploy_current_hi_out == 4'h0)
    else $error("soft reset left config set");
  soft_pulse_a: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset pulse too long");
  read_clears_a: assert property ((flt_rd && fault_valid_in == 8'h00)
    ##1 (fault_valid_in == 8'h00) ##1 (flt_rd && fault_valid_in == 8'h00
    && flt_sel == $past(flt_sel, 2)) |=> reg_resp_out == 8'h00)
    else $error("fault register not cleared by read");
  stretch_cmd_a: assert property (deploy_cmd_in != 8'h00 && idle_cmd_in == 8'h00
    && !deploy_active_in |=> (stretch_active_out & $past(deploy_cmd_in)) == $past(deploy_cmd_in))
    else $error("command did not start stretch timer");
endmodule : squib_regs_properties
bind squib_driver_config_fault_regs squib_regs_properties chk_u (
  .clk_in(clk_in), .resetn_in(resetn_in), .frame_valid_in(frame_valid_in),
  .frame_data_in(frame_data_in), .deploy_active_in(deploy_active_in),
  .deploy_cmd_in(deploy_cmd_in), .idle_cmd_in(idle_cmd_in), .fault_valid_in(fault_valid_in),
  .reg_resp_out(reg_resp_out), .serial_arm_mode_out(serial_arm_mode_out),
  .deploy_period_4ms_out(deploy_period_4ms_out), .deploy_current_hi_out(deploy_current_hi_out),
  .stretch_active_out(stretch_active_out), .soft_reset_out(soft_reset_out));
`default_nettype wire

// file: bench/squib_driver_config_fault_regs_bench.sv
// Self-checking bench for the squib driver register bank
`timescale 1ns/1ps
`default_nettype none
module squib_driver_config_fault_regs_bench;
  import squib_regs_pkg::*;
  localparam int STRETCH_CYC [4] = '{10, 20, 30, 40}; // Shortened stretch periods
  logic        clk_in, resetn_in, deploy_active_in;
  wire         frame_valid_in;
  wire  [15:0] frame_data_in;
  logic [7:0]  deploy_cmd_in, idle_cmd_in, fault_valid_in, reg_resp_out, stretch_active_out;
  logic [7:0]  fault_cond_in [0:7];
  logic [3:0]  arming_input_in, deploy_period_4ms_out, deploy_current_hi_out;
  logic        diag_fault_flag_out, serial_arm_mode_out, soft_reset_out;
  int          fail_count, cmp_count, hits, n;
  int          cyc = 0;

  spi_master_model master_u (.clk_in(clk_in), .frame_valid_out(frame_valid_in),
    .frame_data_out(frame_data_in));
  squib_driver_config_fault_regs #(.STRETCH0_CYCLES(10), .STRETCH1_CYCLES(20),
    .STRETCH2_CYCLES(30), .STRETCH3_CYCLES(40)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .frame_valid_in(frame_valid_in),
    .frame_data_in(frame_data_in), .deploy_active_in(deploy_active_in),
    .deploy_cmd_in(deploy_cmd_in), .idle_cmd_in(idle_cmd_in), .arming_input_in(arming_input_in),
    .fault_valid_in(fault_valid_in), .fault_cond_in(fault_cond_in), .reg_resp_out(reg_resp_out),
    .diag_fault_flag_out(diag_fault_flag_out), .serial_arm_mode_out(serial_arm_mode_out),
    .deploy_period_4ms_out(deploy_period_4ms_out), .deploy_current_hi_out(deploy_current_hi_out),
    .stretch_active_out(stretch_active_out), .soft_reset_out(soft_reset_out));

  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Cut a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Compare one 8-bit result
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Read a register and compare the answer
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    master_u.send(1'b0, a, 8'h00);
    chk("reg_resp_out", exp, reg_resp_out);
  endtask : rd

  // One diagnostic result for a channel
  task automatic flt(input int ch, input logic [7:0] cond);
    @(negedge clk_in);
    fault_cond_in[ch]  = cond;
    fault_valid_in[ch] = 1'b1;
    @(negedge clk_in);
    fault_valid_in = 8'h00;
  endtask : flt

  // Start a timer by command and measure how long it runs
  task automatic stretch(input int ch, input int exp);
    @(negedge clk_in);
    deploy_cmd_in[ch] = 1'b1;
    @(negedge clk_in);
    deploy_cmd_in = 8'h00;
    n = 0;
    while (stretch_active_out[ch] === 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    chk("stretch_len_ok", 8'h01, 8'(n >= exp - 2 && n <= exp + 1));
  endtask : stretch

  // Count soft reset pulses over the next few cycles
  task automatic soft_watch();
    hits = 0;
    for (int i = 0; i < 4; i++) begin
      hits += int'(soft_reset_out === 1'b1);
      @(negedge clk_in);
    end
  endtask : soft_watch

  // Main sequence
  initial begin
    resetn_in = 1'b0;
    deploy_active_in = 1'b0;
    deploy_cmd_in = 8'h00;
    idle_cmd_in = 8'h00;
    arming_input_in = 4'h0;
    fault_valid_in = 8'h00;
    fault_cond_in = '{default: 8'h00};
    fail_count = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    for (int a = 0; a < 3; a++) rd(5'(a), 8'h00);
    master_u.send(1'b1, 5'h01, 8'he1);
    chk("reg_resp_out", 8'he1, reg_resp_out);
    chk("serial_arm_mode_out", 8'h01, 8'(serial_arm_mode_out));
    master_u.send(1'b1, 5'h02, 8'haa);
    chk("deploy_period_4ms_out", 8'h0f, 8'(deploy_period_4ms_out));
    master_u.send(1'b1, 5'h02, 8'h55);
    chk("deploy_current_hi_out", 8'h0f, 8'(deploy_current_hi_out));
    deploy_active_in = 1'b1;
    master_u.send(1'b1, 5'h01, 8'h00);
    chk("reg_resp_out", 8'he1, reg_resp_out);
    master_u.send(1'b1, 5'h02, 8'h00);
    chk("reg_resp_out", 8'h55, reg_resp_out);
    deploy_active_in = 1'b0;
    flt(4, 8'h88);
    flt(5, 8'h0c);
    flt(1, 8'h40);
    chk("diag_fault_flag_out", 8'h01, 8'(diag_fault_flag_out));
    master_u.send(1'b1, 5'h00, 8'h32);
    chk("diag_fault_flag_out", 8'h00, 8'(diag_fault_flag_out));
    rd(5'h06, 8'hbf);
    rd(5'h06, 8'h00);
    rd(5'h04, 8'he0);
    for (int c = 1; c < 8; c++) begin
      flt(2, 8'(1 << c));
      rd(5'h05, {5'h01, 3'(c)});
    end
    rd(5'h10, 8'h00);
    for (int s = 0; s < 4; s++) begin
      master_u.send(1'b1, 5'h01, {2'(s), 6'h00});
      stretch(s, STRETCH_CYC[s]);
    end
    master_u.send(1'b1, 5'h01, 8'h00);
    arming_input_in = 4'h1;
    repeat (10) @(negedge clk_in);
    chk("stretch_active_out", 8'h00, stretch_active_out);
    master_u.send(1'b1, 5'h01, 8'h01);
    repeat (6) @(negedge clk_in);
    chk("stretch_active_out", 8'h03, stretch_active_out);
    arming_input_in = 4'h0;
    master_u.send(1'b1, 5'h03, 8'haa);
    rd(5'h00, 8'h32);
    master_u.send(1'b1, 5'h03, 8'h55);
    soft_watch();
    chk("soft_reset_pulses", 8'h00, 8'(hits));
    rd(5'h01, 8'h01);
    // Command starts channel 0, then arming of pair 0/1 is pulsed: only channel 1 may
    // follow the arming, channel 0 must run out ten cycles after its command
    repeat (20) @(negedge clk_in);
    deploy_cmd_in = 8'h01;
    @(negedge clk_in);
    deploy_cmd_in = 8'h00;
    arming_input_in = 4'h1;
    repeat (4) @(negedge clk_in);
    arming_input_in = 4'h0;
    repeat (7) @(negedge clk_in);
    chk("stretch_active_out", 8'h02, stretch_active_out);
    master_u.send(1'b1, 5'h03, 8'haa);
    master_u.send(1'b1, 5'h03, 8'h55);
    soft_watch();
    chk("soft_reset_pulses", 8'h01, 8'(hits));
    for (int a = 0; a < 3; a++) rd(5'(a), 8'h00);
    print_verdict();
  end
endmodule : squib_driver_config_fault_regs_bench
`default_nettype wire
